// ### design/voice_tdm_port.sv
// Voice serial port: two PCM highways or one GCI bus, APB registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "voice_port_consts.svh"

// Behaviour
// - Global bit picks compressed or linear samples
// - Highway rate equals bit clock or half
// - Global choice of rising or falling edge
// - Slot zero delayed zero to seven clocks
// - Rate, edge, offset, format are global
// - Bit clock sets slot count, up to 128
// - Compressed sample uses one slot per channel
// - Linear word 16 bits, top bits copy sign
// - Per channel transmit lane select
// - Frame sync marks slot zero, MSB first
// - Per channel receive lane, MSB first capture
// - GCI frame each sync on data clock
// - Double pin selects single or double clock
// - Compressed GCI slot: voice A, B, monitor, C/I
// - C/I holds six bits plus MR, MX low
// - Downstream layout equals upstream, bytes routed out
// - Compressed pairs in slots 0-3 or 4-7
// - Linear control slots: two idle bytes, monitor, C/I
// - Linear voice slots carry A and B words
// - Linear control and voice groups swap by pin
// - C/I bytes sent and received MSB first
module voice_tdm_port (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Highway and GCI pins
    input wire logic bit_clock,
    input wire logic highway_frame_sync,
    input wire logic pcm_in_lane_one,
    input wire logic pcm_in_lane_two,
    output logic pcm_out_lane_one,
    output logic pcm_out_lane_one_oe,
    output logic pcm_out_lane_two,
    output logic pcm_out_lane_two_oe,
    input wire logic gci_down_data,
    output logic gci_up_data_out,
    output logic gci_up_data_oe,
    // Strap pins
    input wire logic interface_mode_pin,
    input wire logic slot_group_select_pin,
    input wire logic rate_double_pin,
    input wire logic gci_linear_pin,
    // Voice and control, user side
    input wire logic [7:0][15:0] tx_samples,
    input wire logic [3:0][7:0] up_mon,
    input wire logic [3:0][5:0] up_ci_sig,
    input wire logic [3:0] up_mr_n,
    input wire logic [3:0] up_mx_n,
    output logic [7:0][15:0] rx_samples,
    output logic [7:0] rx_valid,
    output logic [3:0][7:0] down_mon,
    output logic [3:0][7:0] down_ci
);
    localparam int I_BCK = 0;
    localparam int I_FS = 1;
    localparam int I_DR1 = 2;
    localparam int I_DR2 = 3;
    localparam int I_DD = 4;
    localparam int I_MODE = 5;
    localparam int I_TS = 6;
    localparam int I_DBL = 7;
    localparam int I_LIN = 8;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] slot_hit(input logic [6:0] s,
        input logic [6:0] base, input logic l, input logic [2:0] b);
        logic [6:0] d;
        d = s - base;
        // Hit flag and index of the word bit carried now
        slot_hit = l ? {d[6:1] == 6'h00, 4'hF - {d[0], b}}
                     : {d == 7'h00, 1'b0, 3'h7 - b};
    endfunction

    function automatic voice_port_pkg::sample_type tx_word(
        input voice_port_pkg::sample_type s, input logic l);
        tx_word = l ? {s[13], s[13], s[13:0]} : {8'h00, s[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [8:0] raw;
    logic [8:0] s1_q;
    logic [8:0] s2_q;
    logic [8:0] s3_q;
    logic [8:0] f_q;
    logic [8:0] fp_q;

    assign raw = {gci_linear_pin, rate_double_pin, slot_group_select_pin,
        interface_mode_pin, gci_down_data, pcm_in_lane_two,
        pcm_in_lane_one, highway_frame_sync, bit_clock};

    // Level changes only once stages two and three agree
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q <= '0;
            fp_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
            fp_q <= f_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [5:0] cfg_q;
    logic [7:0][15:0] chan_q;
    logic gci;
    logic lin;
    logic half;
    logic fall;
    logic [2:0] off;

    assign gci = f_q[I_MODE];
    assign lin = gci ? f_q[I_LIN] : cfg_q[`CFG_LIN];
    assign half = gci ? f_q[I_DBL] : cfg_q[`CFG_HALF];
    assign fall = gci ? 1'b0 : cfg_q[`CFG_FALL];
    assign off = gci ? 3'h0 : cfg_q[`CFG_OFF_MSB:`CFG_OFF_LSB];

    ////////////////////////////////////////////////////////////////////////
    logic act;
    logic fsa_q;
    logic fs_start;
    logic [11:0] pos_q;
    logic [7:0] frames_q;
    logic [11:0] rel;
    logic [10:0] bidx;
    logic live;
    logic samp;
    logic [6:0] slot;
    logic [2:0] bnum;

    assign act = fall ? (~f_q[I_BCK] & fp_q[I_BCK])
                      : (f_q[I_BCK] & ~fp_q[I_BCK]);
    assign fs_start = act & f_q[I_FS] & ~fsa_q;

    // Edge count since sync; idles saturated until the first sync
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fsa_q <= 1'b0;
            pos_q <= `POS_IDLE;
            frames_q <= 8'h00;
        end else if (act) begin
            fsa_q <= f_q[I_FS];
            if (fs_start) begin
                pos_q <= 12'h000;
                frames_q <= frames_q + 8'h01;
            end else if (pos_q != `POS_IDLE) begin
                pos_q <= pos_q + 12'h001;
            end
        end
    end

    assign rel = pos_q - {9'h000, off};
    assign bidx = half ? rel[11:1] : rel[10:0];
    assign live = (pos_q >= {9'h000, off}) & ~bidx[10];
    // Half rate: sample on the second edge, mid bit
    assign samp = act & live & (~half | rel[0]);
    assign slot = bidx[9:3];
    assign bnum = bidx[2:0];

    ////////////////////////////////////////////////////////////////////////
    logic [7:0][4:0] txh;
    logic [7:0][4:0] rxh;
    voice_port_pkg::sample_type tw;
    logic o1;
    logic o2;
    logic e1;
    logic e2;

    always_comb begin
        o1 = 1'b0;
        o2 = 1'b0;
        e1 = 1'b0;
        e2 = 1'b0;
        tw = '0;
        for (int c = 0; c < 8; c++) begin
            txh[c] = slot_hit(slot, chan_q[c][`CH_TXS_MSB:0], lin,
                bnum);
            rxh[c] = slot_hit(slot, chan_q[c][`CH_RXS_MSB:`CH_RXS_LSB],
                lin, bnum);
            tw = tx_word(tx_samples[c], lin);
            if (!gci && live && txh[c][4]) begin
                if (chan_q[c][`CH_TXL]) begin
                    e2 = 1'b1;
                    o2 = o2 | tw[txh[c][3:0]];
                end else begin
                    e1 = 1'b1;
                    o1 = o1 | tw[txh[c][3:0]];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] gslot;
    logic [1:0] gbyte;
    logic [1:0] pair;
    logic glive;
    logic moncs;
    logic gdrv;
    voice_port_pkg::octet_type gb;
    voice_port_pkg::sample_type gw;

    assign gslot = bidx[7:5];
    assign gbyte = bidx[4:3];
    assign pair = gslot[1:0];
    assign glive = gci & live & (bidx[9:8] == 2'b00);
    assign moncs = gslot[2] == f_q[I_TS];

    always_comb begin
        gb = 8'hFF;
        gdrv = 1'b0;
        gw = tx_word(tx_samples[{pair, gbyte[1]}], 1'b1);
        if (moncs) begin
            gdrv = 1'b1;
            case (gbyte)
                2'd0: gb = lin ? 8'hFF
                    : tx_samples[{pair, 1'b0}][7:0];
                2'd1: gb = lin ? 8'hFF
                    : tx_samples[{pair, 1'b1}][7:0];
                2'd2: gb = up_mon[pair];
                2'd3: gb = {up_ci_sig[pair], up_mr_n[pair],
                    up_mx_n[pair]};
                default: gb = 8'hFF;
            endcase
        end else if (lin) begin
            gdrv = 1'b1;
            gb = gbyte[0] ? gw[7:0] : gw[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic out1_q;
    logic out2_q;
    logic oe1_q;
    logic oe2_q;
    logic du_oe_q;

    // Open drain upstream: pull low for a zero only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
            oe1_q <= 1'b0;
            oe2_q <= 1'b0;
            du_oe_q <= 1'b0;
        end else begin
            out1_q <= o1;
            out2_q <= o2;
            oe1_q <= e1;
            oe2_q <= e2;
            du_oe_q <= glive & gdrv & ~gb[3'h7 - bnum];
        end
    end

    assign pcm_out_lane_one = out1_q;
    assign pcm_out_lane_two = out2_q;
    assign pcm_out_lane_one_oe = oe1_q;
    assign pcm_out_lane_two_oe = oe2_q;
    assign gci_up_data_out = 1'b0;
    assign gci_up_data_oe = du_oe_q;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0][15:0] rsh_q;
    logic [7:0][15:0] rx_q;
    logic [7:0] rxv_q;
    logic [15:0] gsh_q;
    logic [15:0] gfull;
    logic [3:0][7:0] mon_q;
    logic [3:0][7:0] ci_q;

    assign gfull = {gsh_q[14:0], f_q[I_DD]};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rsh_q <= '0;
            rx_q <= '0;
            rxv_q <= 8'h00;
            gsh_q <= 16'h0000;
            mon_q <= '0;
            ci_q <= {4{`CI_IDLE}};
        end else begin
            rxv_q <= 8'h00;
            for (int c = 0; c < 8; c++) begin
                if (samp && !gci && rxh[c][4]) begin
                    rsh_q[c] <= {rsh_q[c][14:0], chan_q[c][`CH_RXL]
                        ? f_q[I_DR2] : f_q[I_DR1]};
                    if (rxh[c][3:0] == 4'h0) begin
                        rx_q[c] <= lin ? {rsh_q[c][14:0], chan_q[c][`CH_RXL]
                            ? f_q[I_DR2] : f_q[I_DR1]}
                            : {8'h00, rsh_q[c][6:0], chan_q[c][`CH_RXL]
                            ? f_q[I_DR2] : f_q[I_DR1]};
                        rxv_q[c] <= 1'b1;
                    end
                end
            end
            if (samp && glive) begin
                gsh_q <= gfull;
                if (bnum == 3'h7) begin
                    if (moncs && gbyte == 2'd2) begin
                        mon_q[pair] <= gfull[7:0];
                    end
                    if (moncs && gbyte == 2'd3) begin
                        ci_q[pair] <= gfull[7:0];
                    end
                    if (moncs && !lin && !gbyte[1]) begin
                        rx_q[{pair, gbyte[0]}] <= {8'h00,
                            gfull[7:0]};
                        rxv_q[{pair, gbyte[0]}] <= 1'b1;
                    end
                    if (!moncs && lin && gbyte[0]) begin
                        rx_q[{pair, gbyte[1]}] <= gfull;
                        rxv_q[{pair, gbyte[1]}] <= 1'b1;
                    end
                end
            end
        end
    end

    assign rx_samples = rx_q;
    assign rx_valid = rxv_q;
    assign down_mon = mon_q;
    assign down_ci = ci_q;

    ////////////////////////////////////////////////////////////////////////
    logic wr;
    logic ch_sel;
    logic hit;
    logic [31:0] rd_q;

    assign wr = psel & penable & pwrite;
    assign ch_sel = (paddr[7:5] == `CH_PAGE) & (paddr[1:0] == 2'b00);
    assign hit = (paddr == `CFG_OFS) | (paddr == `STAT_OFS) | ch_sel;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= 6'h00;
            chan_q <= '0;
        end else if (wr && paddr == `CFG_OFS) begin
            cfg_q <= pwdata[5:0];
        end else if (wr && ch_sel) begin
            chan_q[paddr[4:2]] <= pwdata[15:0];
        end
    end

    // Read data is latched in the setup cycle, so no wait states
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 32'h00000000;
        end else if (psel && !penable) begin
            if (paddr == `CFG_OFS) begin
                rd_q <= {26'h0000000, cfg_q};
            end else if (paddr == `STAT_OFS) begin
                rd_q <= {20'h00000, gci, lin, f_q[I_TS], half, frames_q};
            end else if (ch_sel) begin
                rd_q <= {16'h0000, chan_q[paddr[4:2]]};
            end else begin
                rd_q <= 32'h00000000;
            end
        end
    end

    assign prdata = rd_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_cfg;
        wr && paddr == `CFG_OFS |=> cfg_q == $past(pwdata[5:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg not stored");

    property p_gci_quiet;
        gci && $past(gci) |-> !pcm_out_lane_one_oe && !pcm_out_lane_two_oe;
    endproperty
    a_gci_quiet: assert property (p_gci_quiet)
        else $error("pcm lane driven in gci");

    property p_pcm_du;
        !gci && $past(!gci) |-> !gci_up_data_oe;
    endproperty
    a_pcm_du: assert property (p_pcm_du)
        else $error("du driven in pcm mode");

    property p_fs;
        fs_start |=> pos_q == 12'h000;
    endproperty
    a_fs: assert property (p_fs) else $error("sync missed");

    property p_off;
        $past(!live) |-> !oe1_q && !oe2_q && !du_oe_q;
    endproperty
    a_off: assert property (p_off) else $error("early drive");

    property p_sign;
        lin && !gci |-> tw[15] == tw[13] && tw[14] == tw[13];
    endproperty
    a_sign: assert property (p_sign) else $error("sign copy");

    property p_rxv;
        rxv_q != 8'h00 |-> $past(samp);
    endproperty
    a_rxv: assert property (p_rxv) else $error("stray valid");

    property p_pos_step;
        act && !fs_start && pos_q != `POS_IDLE
            |=> pos_q == $past(pos_q) + 12'h001;
    endproperty
    a_pos_step: assert property (p_pos_step)
        else $error("slot count step");

    c_pcm_rx: cover property (!gci && rxv_q != 8'h00);
    c_gci_rx: cover property (gci && rxv_q != 8'h00);
    c_du: cover property (gci_up_data_oe);
endmodule // voice_tdm_port

// ### design/voice_port_consts.svh
// Register map, field positions and reset values of the voice port
`ifndef VOICE_PORT_CONSTS_SVH
`define VOICE_PORT_CONSTS_SVH
`define CFG_OFS 8'h00
`define STAT_OFS 8'h04
`define CH_PAGE 3'h1
`define CFG_LIN 0
`define CFG_HALF 1
`define CFG_FALL 2
`define CFG_OFF_LSB 3
`define CFG_OFF_MSB 5
`define CH_TXS_MSB 6
`define CH_TXL 7
`define CH_RXS_LSB 8
`define CH_RXS_MSB 14
`define CH_RXL 15
`define CI_IDLE 8'hFF
`define POS_IDLE 12'hFFF
`define FRAME_US 125
`endif

// ### design/voice_port_pkg.sv
// Types shared by the voice port design
package voice_port_pkg;
    typedef logic [15:0] sample_type;
    typedef logic [7:0] octet_type;
endpackage

// ### verification/voice_far_end.sv
// Far-end model: highway switch or GCI line card controller
`timescale 1ns/1ps
module voice_far_end (
    // Clock and frame start
    output logic bit_clock,
    output logic frame_sync,
    // Far end to block
    output logic lane_one_in,
    output logic lane_two_in,
    output logic down_in,
    // Block to far end
    input wire logic lane_one_out,
    input wire logic lane_two_out,
    input wire logic up_wire
);
    localparam int NE = 520;
    logic src [3][NE];
    logic cap [3][NE];
    logic act;
    initial begin
        act = 1'b1;
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        lane_one_in = 1'b0;
        lane_two_in = 1'b1;
        down_in = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Clock runs only inside a frame; data changes mid-bit for margin
    task automatic run_frame(input logic fall);
        act = ~fall;
        // Pin edges kept off the system clock edge to avoid a race
        #2 bit_clock = fall;
        #40 frame_sync = 1'b1;
        for (int e = 0; e <= NE; e++) begin
            #40 bit_clock = act;
            if (e > 0) begin
                cap[0][e-1] = lane_one_out;
                cap[1][e-1] = lane_two_out;
                cap[2][e-1] = up_wire;
            end
            #40 bit_clock = ~act;
            frame_sync = 1'b0;
            if (e < NE) begin
                lane_one_in = src[0][e];
                lane_two_in = src[1][e];
                down_in = src[2][e];
            end
        end
        // Released lines show the inverse, never a stale bit
        lane_one_in = ~lane_one_in;
        lane_two_in = ~lane_two_in;
        down_in = ~down_in;
    endtask
endmodule // voice_far_end

// ### verification/voice_tdm_port_bench.sv
// Self-checking bench for the voice port with a far-end model
`timescale 1ns/1ps
`include "voice_port_consts.svh"
module voice_tdm_port_bench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic bit_clock, highway_frame_sync, pcm_in_lane_one, pcm_in_lane_two;
    logic pcm_out_lane_one, pcm_out_lane_one_oe;
    logic pcm_out_lane_two, pcm_out_lane_two_oe;
    logic gci_down_data, gci_up_data_out, gci_up_data_oe;
    logic interface_mode_pin = 1'b0;
    logic slot_group_select_pin = 1'b0;
    logic rate_double_pin = 1'b0;
    logic gci_linear_pin = 1'b0;
    logic [7:0][15:0] tx_samples = '0;
    logic [3:0][7:0] up_mon = '0;
    logic [3:0][5:0] up_ci_sig = '0;
    logic [3:0] up_mr_n = 4'hF;
    logic [3:0] up_mx_n = 4'hF;
    logic [7:0][15:0] rx_samples;
    logic [7:0] rx_valid;
    logic [3:0][7:0] down_mon, down_ci;
    logic [19:0] exp_q [$];
    logic lin_mode = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    int frames = 0;

    always #5 clock = ~clock;

    voice_tdm_port dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .bit_clock, .highway_frame_sync,
        .pcm_in_lane_one, .pcm_in_lane_two, .pcm_out_lane_one,
        .pcm_out_lane_one_oe, .pcm_out_lane_two, .pcm_out_lane_two_oe,
        .gci_down_data, .gci_up_data_out, .gci_up_data_oe,
        .interface_mode_pin, .slot_group_select_pin, .rate_double_pin,
        .gci_linear_pin, .tx_samples, .up_mon, .up_ci_sig, .up_mr_n,
        .up_mx_n, .rx_samples, .rx_valid, .down_mon, .down_ci);

    voice_far_end far (.bit_clock(bit_clock),
        .frame_sync(highway_frame_sync), .lane_one_in(pcm_in_lane_one),
        .lane_two_in(pcm_in_lane_two), .down_in(gci_down_data),
        .lane_one_out(pcm_out_lane_one_oe ? pcm_out_lane_one : 1'bz),
        .lane_two_out(pcm_out_lane_two_oe ? pcm_out_lane_two : 1'bz),
        .up_wire(gci_up_data_oe ? gci_up_data_out : 1'b1));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [15:0] sx(input logic [15:0] v);
        return {{2{v[13]}}, v[13:0]};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r & m, x);
        check({31'h0, e}, {31'h0, xe});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    // Frame bit p sits at edge index p*(half+1)+offset
    task automatic put(input int l, input int p, input int nb,
            input logic [31:0] v, input logic h, input int o);
        int i;
        for (int k = 0; k < nb; k++) begin
            i = (p + k) * (h + 1) + o;
            far.src[l][i] = v[nb-1-k];
            far.src[l][i+h] = v[nb-1-k];
        end
    endtask

    function automatic logic [31:0] grab(input int l, input int p,
            input int nb, input logic h, input int o);
        logic [31:0] v;
        v = '0;
        for (int k = 0; k < nb; k++)
            v = {v[30:0], far.cap[l][(p + k) * (h + 1) + o]};
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Channels on distinct slots, lanes alternate by channel
    task automatic pcm_case(input logic lin, input logic h, input logic f,
            input logic [2:0] o, input int base);
        logic [15:0] v;
        int sl, nb;
        nb = lin ? 16 : 8;
        lin_mode = lin;
        interface_mode_pin <= 1'b0;
        wr(`CFG_OFS, {26'h0, o, f, h, lin});
        for (int i = 0; i < 1560; i++) far.src[i/520][i%520] = 1'($urandom);
        for (int c = 0; c < 8; c++) begin
            sl = base + c * nb / 8;
            wr(8'h20 + 8'(4 * c), {16'h0, c[0], 7'(sl), c[0], 7'(sl)});
            tx_samples[c] <= 16'($urandom);
            v = 16'($urandom);
            v = lin ? sx(v) : {8'h00, v[7:0]};
            put(c % 2, sl * 8, nb, {16'h0, v}, h, o);
            exp_q.push_back({1'b0, 3'(c), v});
        end
        repeat (10) @(posedge clock);
        far.run_frame(f);
        frames++;
        repeat (20) @(posedge clock);
        for (int c = 0; c < 8; c++) begin
            v = lin ? sx(tx_samples[c]) : {8'h00, tx_samples[c][7:0]};
            sl = (base + c * nb / 8) * 8;
            check(grab(c % 2, sl, nb, h, o), {16'h0, v});
        end
        check(exp_q.size(), 0);
        rd(`STAT_OFS, 32'hFFF, {21'h0, lin, 1'b0, h, 8'(frames)}, 1'b0);
    endtask

    task automatic gci_case(input logic lin, input logic ts, input logic h);
        logic [31:0] d, x;
        logic [7:0] ci;
        logic [3:0][7:0] em, ec;
        int p;
        lin_mode = lin;
        interface_mode_pin <= 1'b1;
        gci_linear_pin <= lin;
        slot_group_select_pin <= ts;
        rate_double_pin <= h;
        wr(`CFG_OFS, {31'h0, lin});
        for (int c = 0; c < 8; c++) tx_samples[c] <= 16'($urandom);
        up_mon <= 32'($urandom);
        up_ci_sig <= 24'($urandom);
        up_mr_n <= 4'($urandom);
        up_mx_n <= 4'($urandom);
        for (int s = 0; s < 8; s++) begin
            p = s % 4;
            d = $urandom;
            if (lin && s[2] != ts) d = {sx(d[31:16]), sx(d[15:0])};
            put(2, s * 32, 32, d, h, 0);
            if (s[2] == ts) begin
                em[p] = d[15:8];
                ec[p] = d[7:0];
            end
            if (s[2] == ts && !lin) begin
                exp_q.push_back({1'b0, 3'(2 * p), 8'h00, d[31:24]});
                exp_q.push_back({1'b0, 3'(2 * p + 1), 8'h00, d[23:16]});
            end
            if (s[2] != ts && lin) begin
                exp_q.push_back({1'b0, 3'(2 * p), d[31:16]});
                exp_q.push_back({1'b0, 3'(2 * p + 1), d[15:0]});
            end
        end
        repeat (10) @(posedge clock);
        far.run_frame(1'b0);
        frames++;
        repeat (20) @(posedge clock);
        for (int s = 0; s < 8; s++) begin
            p = s % 4;
            ci = {up_ci_sig[p], up_mr_n[p], up_mx_n[p]};
            if (s[2] == ts) x = lin ? {16'hFFFF, up_mon[p], ci} :
                {tx_samples[2*p][7:0], tx_samples[2*p+1][7:0], up_mon[p], ci};
            else x = lin ? {sx(tx_samples[2*p]), sx(tx_samples[2*p+1])} :
                32'hFFFFFFFF;
            check(grab(2, s * 32, 32, h, 0), x);
        end
        check(down_mon, em);
        check(down_ci, ec);
        check(exp_q.size(), 0);
        rd(`STAT_OFS, 32'hFFF, {20'h1, lin, ts, h, 8'(frames)}, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Each received sample must match the oldest note, channel included
    always @(negedge clock) begin
        logic [19:0] e;
        for (int c = 0; c < 8; c++) begin
            if (rx_valid[c] === 1'b1) begin
                e = exp_q.size() > 0 ? exp_q.pop_front() : 20'hFFFFF;
                check({13'h0, 3'(c), lin_mode ? rx_samples[c] :
                    {8'h00, rx_samples[c][7:0]}}, {12'h0, e});
            end
        end
    end

    initial begin
        // Seven frames of about 42 us each plus bus traffic
        #500000;
        num_errors++;
        print_verdict;
    end

    initial begin
        void'($urandom(7));
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(`CFG_OFS, 32'hFFFFFFFF, 32'h0, 1'b0);
        wr(`CFG_OFS, 32'h0000002D);
        rd(`CFG_OFS, 32'h3F, 32'h2D, 1'b0);
        wr(8'h3C, 32'h0000A5C3);
        rd(8'h3C, 32'hFFFF, 32'hA5C3, 1'b0);
        rd(8'h10, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(`STAT_OFS, 32'h00000FFF);
        rd(`STAT_OFS, 32'hFFF, 32'h400, 1'b0);
        pcm_case(1'b0, 1'b0, 1'b0, 3'h0, 0);
        pcm_case(1'b1, 1'b0, 1'b1, 3'h5, 10);
        pcm_case(1'b0, 1'b1, 1'b0, 3'h7, 20);
        gci_case(1'b0, 1'b0, 1'b0);
        gci_case(1'b1, 1'b1, 1'b1);
        gci_case(1'b0, 1'b1, 1'b1);
        gci_case(1'b1, 1'b0, 1'b0);
        print_verdict;
    end
endmodule // voice_tdm_port_bench
